// ### rtl/acss_sequencer.sv
`include "acss_defines.svh"
// Behaviour
// - convert every enabled mask bit, highest bit first down to bit zero
// - tagged layout code 11 puts the 4-bit channel tag in result top bits
// - monitor bits 15..12 use tags 1111..1100 and selectors 88, F8, 98, DE
// - bits 11..8 pick pairs 67,45,23,01; bits 7..0 single inputs N8
// - supply entry uses selector 98 and forces one-third gain
// - temperature entry uses selector DE and forces unity gain
// - overrides last one conversion and never change stored register values
// - zero-offset entry shorts selector output to ground, no auto correction
// - common-mode entry uses selector F8 and forces unity gain
// - mask bits of absent inputs on reduced variants ignore writes
// - delay code 0..7 waits 0,8,16,32,64,128,256,512 decimation periods
// - intra-cycle delay only between conversions of the same cycle
// - during that delay converter is in standby while readback shows 11
// - selector moves to next entry as soon as a conversion ends
// - continuous cycles separated by the 24-bit inter-cycle count
// - internal counter loads the count, decrements, launches at zero
// - count above warm-up: shutdown between cycles, warm-up restarts at 256
// - count below warm-up: standby between cycles
// - power state readback is 11 throughout cycles and waits
// - any mask bit set means sequencing; zero mask uses the plain selector
// - sequencing starts on power state 11 write and holds until done/aborted
// - repeat select 11 repeats cycles, otherwise one cycle then idle state
// - each conversion raises data ready and updates the result at once
module acss_sequencer #(
  parameter logic [1:0] VARIANT = `ACSS_VAR_FULL
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_decimation_clock_tick,
  input wire logic i_reg_wr,
  input wire logic [3:0] i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic i_scan_wr,
  input wire logic [23:0] i_scan_wdata,
  input wire logic i_pwr_wr,
  input wire logic [1:0] i_pwr_wdata,
  input wire logic [1:0] i_run_repeat_select,
  input wire logic [1:0] i_data_format,
  input wire logic [2:0] i_gain_field,
  input wire logic [7:0] i_input_selector_code,
  input wire logic i_conv_done,
  input wire logic [23:0] i_conv_data,
  output logic [23:0] o_scan_rdata,
  output logic [23:0] o_timer_rdata,
  output logic [1:0] o_pwr_rdata,
  output logic o_scan_active,
  output logic o_conv_start,
  output logic [7:0] o_sel,
  output logic [2:0] o_gain,
  output logic o_short_gnd,
  output logic [1:0] o_pwr_internal,
  output logic [31:0] o_result_register,
  output logic o_data_ready
);
  acss_pkg::acss_state_s st_reg;
  acss_pkg::acss_state_s st_next;
  logic [23:0] scan_reg;
  logic [23:0] timer_reg;
  logic [1:0] pwr_field_reg;
  logic [15:0] avail;
  logic [15:0] mask;
  logic [3:0] first_idx;
  logic first_found;
  logic [3:0] nxt_idx;
  logic nxt_found;
  logic [15:0] rest;
  logic [7:0] map_sel;
  logic [3:0] map_tag;
  logic [2:0] map_gain;
  logic map_short;
  logic [9:0] dly_len;

  always_comb begin
    unique case (VARIANT)
      `ACSS_VAR_ONE_PAIR: avail = `ACSS_MASK_ONE_PAIR;
      `ACSS_VAR_TWO_PAIR: avail = `ACSS_MASK_TWO_PAIR;
      default: avail = `ACSS_MASK_FULL;
    endcase
  end

  // host-visible registers; scan/timer hold programmed values only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scan_reg <= 24'h000000;
      timer_reg <= 24'h000000;
      pwr_field_reg <= 2'h0;
    end else begin
      if (i_scan_wr) begin
        scan_reg <= i_scan_wdata & {8'hFF, avail};
      end
      if (i_reg_wr && i_reg_addr == `ACSS_TIMER_OFFSET) begin
        timer_reg <= i_reg_wdata;
      end
      if (i_pwr_wr) begin
        pwr_field_reg <= i_pwr_wdata;
      end else if (st_reg.done) begin
        pwr_field_reg <= (i_run_repeat_select == `ACSS_PWR_STANDBY) ? `ACSS_PWR_STANDBY
                                                                    : `ACSS_PWR_SHUTDOWN;
      end
    end
  end

  assign mask = scan_reg[15:0];
  assign rest = st_reg.pending & ~(16'h0001 << st_reg.cur);

  // highest set bit search; loop runs ascending so the top bit wins
  always_comb begin
    first_idx = 4'h0;
    first_found = 1'b0;
    nxt_idx = 4'h0;
    nxt_found = 1'b0;
    for (int i = 0; i < `ACSS_MASK_W; i++) begin
      if (mask[i]) begin
        first_idx = 4'(i);
        first_found = 1'b1;
      end
      if (rest[i]) begin
        nxt_idx = 4'(i);
        nxt_found = 1'b1;
      end
    end
  end

  always_comb begin
    unique case (scan_reg[`ACSS_DLY_MSB:`ACSS_DLY_LSB])
      3'h0: dly_len = 10'h000;
      default: dly_len = 10'(10'h004 << scan_reg[`ACSS_DLY_MSB:`ACSS_DLY_LSB]);
    endcase
  end

  acss_entry_map u_map (
    .i_idx(st_next.cur),
    .i_gain(i_gain_field),
    .o_sel(map_sel),
    .o_tag(map_tag),
    .o_gain(map_gain),
    .o_short_gnd(map_short)
  );

  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.drdy = 1'b0;
    st_next.done = 1'b0;
    unique case (st_reg.state)
      acss_pkg::ACSS_IDLE: begin
        if (i_pwr_wr && i_pwr_wdata == `ACSS_PWR_RUN && first_found) begin
          st_next.state = acss_pkg::ACSS_CONV;
          st_next.pending = mask;
          st_next.cur = first_idx;
          st_next.start = 1'b1;
          st_next.pwr = `ACSS_PWR_RUN;
        end
      end
      acss_pkg::ACSS_CONV: begin
        if (i_conv_done) begin
          st_next.drdy = 1'b1;
          st_next.result = {8'h00, i_conv_data};
          if (i_data_format == `ACSS_FMT_TAGGED) begin
            st_next.result = {st_reg.cur, 4'h0, i_conv_data};
          end
          st_next.pending = rest;
          if (nxt_found) begin
            st_next.cur = nxt_idx;
            if (dly_len == 10'h000) begin
              st_next.start = 1'b1;
            end else begin
              st_next.state = acss_pkg::ACSS_DLY;
              st_next.dly_cnt = dly_len;
              st_next.pwr = `ACSS_PWR_STANDBY;
            end
          end else if (i_run_repeat_select == `ACSS_PWR_RUN) begin
            st_next.state = acss_pkg::ACSS_WAIT;
            st_next.wait_cnt = timer_reg;
            st_next.pwr = (timer_reg > `ACSS_WARMUP) ? `ACSS_PWR_SHUTDOWN : `ACSS_PWR_STANDBY;
            if (timer_reg == 24'h000000) begin
              st_next.state = acss_pkg::ACSS_CONV;
              st_next.pending = mask;
              st_next.cur = first_idx;
              st_next.start = 1'b1;
              st_next.pwr = `ACSS_PWR_RUN;
            end
          end else begin
            st_next.state = acss_pkg::ACSS_IDLE;
            st_next.done = 1'b1;
            st_next.pwr = (i_run_repeat_select == `ACSS_PWR_STANDBY) ? `ACSS_PWR_STANDBY
                                                                     : `ACSS_PWR_SHUTDOWN;
          end
        end
      end
      acss_pkg::ACSS_DLY: begin
        if (i_decimation_clock_tick) begin
          st_next.dly_cnt = st_reg.dly_cnt - 10'h001;
          if (st_reg.dly_cnt == 10'h001) begin
            st_next.state = acss_pkg::ACSS_CONV;
            st_next.start = 1'b1;
            st_next.pwr = `ACSS_PWR_RUN;
          end
        end
      end
      acss_pkg::ACSS_WAIT: begin
        if (i_decimation_clock_tick) begin
          st_next.wait_cnt = st_reg.wait_cnt - 24'h000001;
          if (st_reg.wait_cnt == `ACSS_WARMUP + 24'h000001) begin
            st_next.pwr = `ACSS_PWR_STANDBY;
          end
          if (st_reg.wait_cnt == 24'h000001) begin
            st_next.state = acss_pkg::ACSS_CONV;
            st_next.pending = mask;
            st_next.cur = first_idx;
            st_next.start = 1'b1;
            st_next.pwr = `ACSS_PWR_RUN;
          end
        end
      end
      default: st_next.state = acss_pkg::ACSS_IDLE;
    endcase
    // abort: power field rewritten to not-run, or mask cleared
    if (st_reg.state != acss_pkg::ACSS_IDLE &&
        ((i_pwr_wr && i_pwr_wdata != `ACSS_PWR_RUN) || !first_found)) begin
      st_next.state = acss_pkg::ACSS_IDLE;
      st_next.start = 1'b0;
      st_next.pwr = i_pwr_wr ? i_pwr_wdata : `ACSS_PWR_STANDBY;
    end
    // selector/gain recomputed per entry, never stored to host registers
    st_next.sel = map_sel;
    st_next.gain = map_gain;
    st_next.short_gnd = map_short;
    if (st_next.state == acss_pkg::ACSS_IDLE) begin
      st_next.sel = i_input_selector_code;
      st_next.gain = i_gain_field;
      st_next.short_gnd = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '{state: acss_pkg::ACSS_IDLE, pwr: `ACSS_PWR_SHUTDOWN, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_scan_rdata = scan_reg;
  assign o_timer_rdata = timer_reg;
  assign o_pwr_rdata = (st_reg.state != acss_pkg::ACSS_IDLE) ? `ACSS_PWR_RUN : pwr_field_reg;
  assign o_scan_active = first_found;
  assign o_conv_start = st_reg.start;
  assign o_sel = st_reg.sel;
  assign o_gain = st_reg.gain;
  assign o_short_gnd = st_reg.short_gnd;
  assign o_pwr_internal = st_reg.pwr;
  assign o_result_register = st_reg.result;
  assign o_data_ready = st_reg.drdy;
endmodule

// ### rtl/acss_defines.svh
`ifndef ACSS_DEFINES_SVH
`define ACSS_DEFINES_SVH

`define ACSS_TIMER_OFFSET 4'h8
`define ACSS_MASK_W 16
`define ACSS_TAG_W 4
`define ACSS_SEL_W 8
`define ACSS_BIT_OFFSET 4'hF
`define ACSS_BIT_VCM 4'hE
`define ACSS_BIT_SUPPLY 4'hD
`define ACSS_BIT_TEMP 4'hC
`define ACSS_SEL_OFFSET 8'h88
`define ACSS_SEL_VCM 8'hF8
`define ACSS_SEL_SUPPLY 8'h98
`define ACSS_SEL_TEMP 8'hDE
`define ACSS_SEL_SE_LOW 4'h8
`define ACSS_DIFF_BASE 4'h8
`define ACSS_PWR_SHUTDOWN 2'h0
`define ACSS_PWR_STANDBY 2'h2
`define ACSS_PWR_RUN 2'h3
`define ACSS_GAIN_THIRD 3'h0
`define ACSS_GAIN_ONE 3'h1
`define ACSS_FMT_TAGGED 2'h3
`define ACSS_WARMUP 24'h000100
`define ACSS_DLY_LSB 20
`define ACSS_DLY_MSB 22
`define ACSS_RESULT_W 32
`define ACSS_DATA_W 24
`define ACSS_VAR_FULL 2'h0
`define ACSS_VAR_ONE_PAIR 2'h1
`define ACSS_VAR_TWO_PAIR 2'h2
`define ACSS_MASK_ONE_PAIR 16'hF103
`define ACSS_MASK_TWO_PAIR 16'hF30F
`define ACSS_MASK_FULL 16'hFFFF

`endif

// ### rtl/acss_pkg.sv
package acss_pkg;
  typedef enum logic [2:0] {
    ACSS_IDLE = 3'b000,
    ACSS_CONV = 3'b001,
    ACSS_DLY = 3'b010,
    ACSS_WAIT = 3'b011
  } acss_state_e;

  typedef struct packed {
    acss_state_e state;
    logic [15:0] pending;
    logic [3:0] cur;
    logic [9:0] dly_cnt;
    logic [23:0] wait_cnt;
    logic [1:0] pwr;
    logic [7:0] sel;
    logic [2:0] gain;
    logic short_gnd;
    logic start;
    logic [31:0] result;
    logic drdy;
    logic done;
  } acss_state_s;
endpackage

// ### rtl/acss_entry_map.sv
`include "acss_defines.svh"
// maps a mask bit index to its selector, tag and gain override
module acss_entry_map (
  input wire logic [3:0] i_idx,
  input wire logic [2:0] i_gain,
  output logic [7:0] o_sel,
  output logic [3:0] o_tag,
  output logic [2:0] o_gain,
  output logic o_short_gnd
);
  always_comb begin
    o_tag = i_idx;
    o_gain = i_gain;
    o_short_gnd = 1'b0;
    o_sel = {1'b0, i_idx[2:0], `ACSS_SEL_SE_LOW};
    if (i_idx[3] && i_idx[2]) begin
      unique case (i_idx)
        `ACSS_BIT_OFFSET: begin
          o_sel = `ACSS_SEL_OFFSET;
          o_short_gnd = 1'b1;
        end
        `ACSS_BIT_VCM: begin
          o_sel = `ACSS_SEL_VCM;
          o_gain = `ACSS_GAIN_ONE;
        end
        `ACSS_BIT_SUPPLY: begin
          o_sel = `ACSS_SEL_SUPPLY;
          o_gain = `ACSS_GAIN_THIRD;
        end
        default: begin
          o_sel = `ACSS_SEL_TEMP;
          o_gain = `ACSS_GAIN_ONE;
        end
      endcase
    end else if (i_idx[3]) begin
      // pairs: bit 11 -> 0x67 ... bit 8 -> 0x01
      o_sel = {1'b0, i_idx[1:0], 1'b0, 1'b0, i_idx[1:0], 1'b1};
    end
  end
endmodule

// ### verification/acss_conv_model.sv
// converter stand-in: answers each start after i_lat cycles
module acss_conv_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [7:0] i_sel,
  input wire logic [3:0] i_lat,
  output logic o_done,
  output logic [23:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg = 4'h0;
  logic [23:0] val_reg = 24'h0;
  logic done_reg = 1'b0;
  always @(posedge i_clk) begin
    done_reg <= 1'b0;
    if (i_rst) begin
      cnt_reg <= 4'h0;
    end else if (i_start) begin
      cnt_reg <= i_lat;
      val_reg <= {16'hA5C3, i_sel};
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      done_reg <= cnt_reg == 4'h1;
    end
  end
  assign o_done = done_reg;
  // data is only good with the pulse, the inverse shows otherwise
  assign o_data = done_reg ? val_reg : ~val_reg;
endmodule

// ### verification/acss_sequencer_chk.sv
module acss_sequencer_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pwr_wr,
  input wire logic [1:0] i_pwr_wdata,
  input wire logic i_conv_done,
  input wire logic o_scan_active,
  input wire logic o_conv_start,
  input wire logic [7:0] o_sel,
  input wire logic [2:0] o_gain,
  input wire logic o_short_gnd,
  input wire logic [1:0] o_pwr_internal,
  input wire logic [1:0] o_pwr_rdata,
  input wire logic o_data_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ready_after_done_a: assert property (i_conv_done && o_pwr_rdata == 2'h3 |=> o_data_ready)
    else $error("no data ready after done");
  supply_gain_a: assert property (o_conv_start && o_sel == 8'h98 |-> o_gain == 3'h0)
    else $error("supply gain wrong");
  temp_gain_a: assert property (o_conv_start && o_sel == 8'hDE |-> o_gain == 3'h1)
    else $error("temperature gain wrong");
  cm_gain_a: assert property (o_conv_start && o_sel == 8'hF8 |-> o_gain == 3'h1)
    else $error("common mode gain wrong");
  offset_short_a: assert property (o_conv_start && o_sel == 8'h88 |-> o_short_gnd)
    else $error("offset entry not shorted");
  run_readback_a: assert property (o_conv_start |-> o_pwr_rdata == 2'h3 && o_pwr_internal == 2'h3)
    else $error("power state wrong at start");
  start_on_write_a: assert property (i_pwr_wr && i_pwr_wdata == 2'h3 && o_scan_active && o_pwr_rdata != 2'h3
    |=> o_conv_start) else $error("no start after power write");
  zero_mask_a: assert property (!o_scan_active && !$past(o_scan_active) |-> !o_conv_start)
    else $error("start with empty mask");
  cover property (o_conv_start && o_sel == 8'h98);
  cover property (o_data_ready && o_pwr_internal == 2'h2);
  cover property (o_pwr_internal == 2'h0 && o_pwr_rdata == 2'h3);
endmodule
bind acss_sequencer acss_sequencer_chk acss_sequencer_chk_inst (.i_clk, .i_rst, .i_pwr_wr, .i_pwr_wdata,
  .i_conv_done, .o_scan_active, .o_conv_start, .o_sel, .o_gain, .o_short_gnd, .o_pwr_internal,
  .o_pwr_rdata, .o_data_ready);

// ### verification/test_adc_channel_scan_sequencer.sv
module test_adc_channel_scan_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst = 1, i_decimation_clock_tick = 0, i_reg_wr = 0, i_scan_wr = 0, i_pwr_wr = 0, i_conv_done;
  logic o_scan_active, o_conv_start, o_short_gnd, o_data_ready;
  logic [3:0] i_reg_addr = 4'h8, lat = 4'h3;
  logic [23:0] i_reg_wdata = 0, i_scan_wdata = 0, i_conv_data, o_scan_rdata, o_timer_rdata, v1_scan;
  logic [1:0] i_pwr_wdata = 0, i_run_repeat_select = 0, i_data_format = 2'h3, o_pwr_rdata, o_pwr_internal, tc = 0;
  logic [2:0] i_gain_field = 3'h5, o_gain;
  logic [7:0] i_input_selector_code = 8'h3C, o_sel;
  logic [31:0] o_result_register;
  int fails = 0, comparisons = 0, waited;
  int waited_tab[3] = '{3, 256, 300};
  acss_sequencer acss_sequencer_inst (.i_clk, .i_rst, .i_decimation_clock_tick, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .i_scan_wr, .i_scan_wdata, .i_pwr_wr, .i_pwr_wdata, .i_run_repeat_select, .i_data_format, .i_gain_field,
    .i_input_selector_code, .i_conv_done, .i_conv_data, .o_scan_rdata, .o_timer_rdata, .o_pwr_rdata,
    .o_scan_active, .o_conv_start, .o_sel, .o_gain, .o_short_gnd, .o_pwr_internal, .o_result_register,
    .o_data_ready);
  acss_sequencer #(.VARIANT(2'h1)) acss_sequencer_inst1 (.i_clk, .i_rst, .i_decimation_clock_tick, .i_reg_wr,
    .i_reg_addr, .i_reg_wdata, .i_scan_wr, .i_scan_wdata, .i_pwr_wr(1'b0), .i_pwr_wdata, .i_run_repeat_select,
    .i_data_format, .i_gain_field, .i_input_selector_code, .i_conv_done, .i_conv_data, .o_scan_rdata(v1_scan),
    .o_timer_rdata(), .o_pwr_rdata(), .o_scan_active(), .o_conv_start(), .o_sel(), .o_gain(), .o_short_gnd(),
    .o_pwr_internal(), .o_result_register(), .o_data_ready());
  acss_conv_model acss_conv_model_inst (.i_clk, .i_rst, .i_start(o_conv_start), .i_sel(o_sel), .i_lat(lat),
    .o_done(i_conv_done), .o_data(i_conv_data));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  // decimation tick every fourth cycle
  always @(posedge i_clk) begin
    #1;
    tc = tc + 2'h1;
    i_decimation_clock_tick = tc == 2'h0;
  end
  task final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // k: 0 channel enable, 1 wait count, 2 power field, 3 unmapped address
  task wr(input int k, input logic [23:0] d);
    i_scan_wr = k == 0;
    i_reg_wr = k[0];
    i_pwr_wr = k == 2;
    i_reg_addr = (k == 3) ? 4'h9 : 4'h8;
    i_scan_wdata = d;
    i_reg_wdata = d;
    i_pwr_wdata = d[1:0];
    step(1);
    {i_scan_wr, i_reg_wr, i_pwr_wr} = 3'h0;
  endtask
  task wt(input bit rdy);
    waited = 0;
    if (rdy) step(1);
    while ((rdy ? o_data_ready : o_conv_start) !== 1'b1) begin
      step(1);
      waited++;
      if (waited > 3000) begin
        fails++;
        final_report();
      end
    end
  endtask
  function automatic logic [7:0] esel(input int i);
    case (i)
      15: return 8'h88;
      14: return 8'hF8;
      13: return 8'h98;
      12: return 8'hDE;
      default: return (i < 8) ? {4'(i), 4'h8} : {4'(2 * i - 16), 4'(2 * i - 15)};
    endcase
  endfunction
  task scan(input logic [15:0] m, input int d);
    bit first;
    first = 1;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        wt(0);
        if (first) chk("lead", waited, 0);
        else chk("gap", waited + 4 >= 4 * d && waited <= 4 * d + 4, 1);
        first = 0;
        chk("sel", o_sel, esel(i));
        chk("gain", o_gain, (i == 13) ? 3'h0 : (i == 14 || i == 12) ? 3'h1 : 3'h5);
        wt(1);
        chk("result", o_result_register, {(i_data_format == 2'h3) ? 4'(i) : 4'h0, 4'h0, 16'hA5C3, esel(i)});
        if (d > 0 && (m & ((16'h1 << i) - 16'h1)) != 0) begin
          chk("dly pwr", {o_pwr_internal, o_pwr_rdata}, 4'hB);
          chk("advance", o_sel !== esel(i), 1);
        end
      end
    end
  endtask
  initial begin
    step(5);
    i_rst = 0;
    wr(0, 24'h00FFFF);
    chk("variant", v1_scan, 24'h00F103);
    wr(2, 24'h3);
    scan(16'hFFFF, 0);
    step(3);
    chk("end pwr", o_pwr_internal, 2'h0);
    chk("keep", {o_scan_rdata, o_sel, o_gain}, {24'h00FFFF, 8'h3C, 3'h5});
    $display("test full scan done");
    i_data_format = 2'h0;
    lat = 4'hB;
    for (int c = 0; c < 8; c++) begin
      wr(0, {1'b0, 3'(c), 4'h0, 16'h8101});
      wr(2, 24'h3);
      scan(16'h8101, (c == 0) ? 0 : 4 << c);
      step(3);
    end
    $display("test delay codes done");
    i_run_repeat_select = 2'h3;
    wr(0, 24'h001000);
    foreach (waited_tab[j]) begin
      wr(1, 24'(waited_tab[j]));
      chk("timer rd", o_timer_rdata, waited_tab[j]);
      wr(2, 24'h3);
      scan(16'h1000, 0);
      step(2);
      chk("idle pwr", o_pwr_internal, (waited_tab[j] > 256) ? 2'h0 : 2'h2);
      chk("rd pwr", o_pwr_rdata, 2'h3);
      wt(0);
      chk("period", waited + 12 >= 4 * waited_tab[j] && waited <= 4 * waited_tab[j] + 4, 1);
      wr(2, 24'h0);
      step(20);
    end
    $display("test continuous done");
    wr(3, 24'h00ABCD);
    chk("unmapped", o_timer_rdata, 24'd300);
    wr(0, 24'h0);
    wr(2, 24'h3);
    step(4);
    chk("zero mask", {o_scan_active, o_sel}, {1'b0, 8'h3C});
    $display("test zero mask done");
    final_report();
  end
endmodule
